// ### verilog/mpgc_pkg.sv
// Shared constants for the port group block
package mpgc_pkg;

  // ----------------------------------------------------------------
  // Port table
  // ----------------------------------------------------------------
  localparam int NPORT = 10;
  localparam int PW = 8;
  localparam int PORT_NUM [NPORT] = '{0, 1, 2, 3, 4, 5, 6, 7, 12, 13};
  localparam int P0_IDX = 0;
  localparam int P4_IDX = 4;
  localparam int P6_IDX = 6;
  localparam int P12_IDX = 8;
  localparam int P13_IDX = 9;
  localparam logic [7:0] PIN_VALID [NPORT] = '{8'hbf, 8'hff, 8'hff, 8'hff, 8'hff,
                                               8'hff, 8'hff, 8'h07, 8'hff, 8'h03};
  localparam logic [7:0] INPUT_ONLY [NPORT] = '{8'h81, 8'h00, 8'h00, 8'h00, 8'h00,
                                                8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] OPEN_DRAIN [NPORT] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                                8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
  localparam int TOTAL_PINS = 68;
  localparam int INPUT_ONLY_PINS = 2;
  localparam int INT_PINS = 6;
  localparam int HIGH_GROUP_BASE = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [1:0] DATA_PAGE = 2'h0;
  localparam logic [1:0] DIR_PAGE = 2'h1;
  localparam logic [7:0] PULL_LOW_OFS = 8'h80;
  localparam logic [7:0] PULL_HIGH_OFS = 8'h84;
  localparam logic [7:0] MEMEXP_OFS = 8'h88;
  localparam logic [7:0] ALTSEL_OFS = 8'h8c;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] MEMEXP_RESET = 8'h00;
  localparam logic [7:0] ALTSEL_RESET = 8'h00;
  localparam int MEMEXP_P4_OUT_BIT = 0;
  localparam int MEMEXP_ENABLE_BIT = 1;
  localparam int ALT_RTP_BIT = 0;
  localparam int ALT_ANO_BIT = 1;
  localparam logic [7:0] P6_EXP_OUT_MASK = 8'hb0;
  localparam logic [7:0] P6_EXP_IN_MASK = 8'h40;
  localparam int P6_WAIT_BIT = 6;

endpackage

// ### verilog/mpgc_bank_if.sv
// Carrier between the top and one port bank
`timescale 1ns/1ps
`default_nettype none
interface mpgc_bank_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] pinIn;
  logic [7:0] altOut;
  logic [7:0] altDrive;
  logic pullGroup;
  logic analogue;
  logic [7:0] readVal;
  logic [7:0] outVal;
  logic [7:0] oeVal;
  logic [7:0] pullVal;
  modport ctrl (output latch, dir, pinIn, altOut, altDrive, pullGroup, analogue,
                input readVal, outVal, oeVal, pullVal);
  modport bank (input latch, dir, pinIn, altOut, altDrive, pullGroup, analogue,
                output readVal, outVal, oeVal, pullVal);
endinterface
`default_nettype wire

// ### verilog/mpgc_port_bank.sv
// Pin resolution for one port: drive, enable, pull-up and read value
`timescale 1ns/1ps
`default_nettype none
module mpgc_port_bank
  import mpgc_pkg::*;
#(
  parameter logic [7:0] VALID = 8'hff,
  parameter logic [7:0] ODRAIN = 8'h00,
  parameter logic [7:0] MASK_PULL = 8'h00
) (
  mpgc_bank_if.bank bif
);

  logic [7:0] outMode;
  logic [7:0] inMode;
  logic [7:0] drive;

  // Analogue use removes all digital drive and pull-up
  assign outMode = ~bif.dir & VALID & {8{~bif.analogue}};
  assign inMode = bif.dir & VALID & {8{~bif.analogue}};
  assign drive = (bif.altDrive & bif.altOut) | (~bif.altDrive & bif.latch);

  // Open-drain pins only ever pull low
  assign bif.outVal = outMode & ~ODRAIN & drive;                     // [R13]
  assign bif.oeVal = outMode & (~ODRAIN | ~drive);                   // [R13]
  // Group pull-up on input pins, mask option on open-drain pins
  assign bif.pullVal = inMode & ((~ODRAIN & {8{bif.pullGroup}}) |
                                 (ODRAIN & MASK_PULL));              // [R21] [R13]
  // Pin level in input mode, latch in output mode
  assign bif.readVal = VALID & ((bif.dir & bif.pinIn) | (~bif.dir & bif.latch)); // [R20]

endmodule
`default_nettype wire

// ### verilog/mpgc_top.sv
// Port group block: latches, directions, pull-ups and APB register access
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01: Port 0 has seven pins; bits 1-5 have direction bits, 0 and 7 input only.
// R02: Port 0 input pins share one pull-up group bit in the low pull-up register; the code gives input-only bits 0 and 7 no pull-up.
// R03: Reset puts all port 0 pins in input mode.
// R04: Level change on a port 0 output pin raises its interrupt request.
// R05: Software masks interrupts of port 0 pins used as outputs.
// R06: Port 1 has eight latched pins with per-pin direction.
// R07: Port 1 input pins share one pull-up group bit.
// R08: Reset puts all port 1 pins in input mode.
// R09: Software keeps pull-ups off port 1 pins used as analogue inputs.
// R10: Port 2 has eight latched pins, per-pin direction, group pull-up.
// R11: Reset puts all port 2 pins in input mode.
// R12: Software sets direction of port 2 bits 5, 6 to read them in serial bus mode.
// R13: Port 6 low nibble is open-drain with mask-option pull-ups only.
// R14: Port 7 has three pins with per-pin direction.
// R15: Port 12 has eight pins, per-pin direction, realtime output alternate.
// R16: Port 13 has two pins, per-pin direction, analogue output alternate.
// R17: Port 4 direction comes from the memory expansion mode register.
// R18: Sixty-eight pins in all, two input only, sixty-six bidirectional.
// R19: In expansion mode port 6 high bits carry read, write, wait, address strobe.
// R20: Reads give pin level for inputs, latch for outputs; writes always hit latch.
// R21: Pull-ups act only on pins in input mode.
module mpgc_top
  import mpgc_pkg::*;
#(
  parameter logic [7:0] P6_MASK_PULL = 8'h00
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPORT-1:0][7:0] pinIn,
  output logic [NPORT-1:0][7:0] pinOut,
  output logic [NPORT-1:0][7:0] pinOe,
  output logic [NPORT-1:0][7:0] pullupEn,
  output logic [INT_PINS-1:0] extIntReq,
  input wire logic [7:0] rtOutBits,
  input wire logic expRdStrobe,
  input wire logic expWrStrobe,
  input wire logic expAddrStrobe,
  output logic expWaitIn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NPORT-1:0][7:0] latch_reg;
  logic [NPORT-1:0][7:0] dir_reg;
  logic [NPORT-1:0][7:0] dirEff;
  logic [NPORT-1:0][7:0] readAll;
  logic [NPORT-1:0][7:0] outAll;
  logic [NPORT-1:0][7:0] oeAll;
  logic [NPORT-1:0][7:0] pullAll;
  logic [7:0] pullLow_reg;
  logic [7:0] pullHigh_reg;
  logic [7:0] memExp_reg;
  logic [7:0] altSel_reg;
  logic [INT_PINS-1:0] intLvl_reg;
  logic armed_reg;
  logic expMode;

  assign expMode = memExp_reg[MEMEXP_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [3:0] idx;
  logic idxOk;
  logic isData;
  logic isDir;
  logic hit;
  logic [31:0] rd_next;
  logic wrAcc;

  assign idx = paddr[5:2];
  assign idxOk = (idx < 4'(NPORT)) && (paddr[1:0] == 2'b00);
  assign isData = (paddr[7:6] == DATA_PAGE) && idxOk;
  assign isDir = (paddr[7:6] == DIR_PAGE) && idxOk;
  assign hit = isData || isDir || (paddr == PULL_LOW_OFS) || (paddr == PULL_HIGH_OFS) ||
               (paddr == MEMEXP_OFS) || (paddr == ALTSEL_OFS);
  assign wrAcc = psel && penable && pwrite && hit;

  always_comb begin
    rd_next = 32'h0;
    if (isData) begin
      rd_next = {24'h0, readAll[idx]};                               // [R20]
    end else if (isDir) begin
      rd_next = {24'h0, dirEff[idx]};
    end else if (paddr == PULL_LOW_OFS) begin
      rd_next = {24'h0, pullLow_reg};
    end else if (paddr == PULL_HIGH_OFS) begin
      rd_next = {24'h0, pullHigh_reg};
    end else if (paddr == MEMEXP_OFS) begin
      rd_next = {24'h0, memExp_reg};
    end else if (paddr == ALTSEL_OFS) begin
      rd_next = {24'h0, altSel_reg};
    end
  end

  // ----------------------------------------------------------------
  // APB answer: zero wait, data and error prepared in setup
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0 : rd_next;
        pslverr <= !hit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output latches: a write always lands in the latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_reg <= {NPORT{LATCH_RESET}};
    end else if (wrAcc && isData) begin
      latch_reg[idx] <= pwdata[7:0] & PIN_VALID[idx];                // [R20] [R06] [R10]
    end
  end

  // ----------------------------------------------------------------
  // Direction registers, input-only bits stay set
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_reg <= {NPORT{DIR_RESET}};                                 // [R03] [R08] [R11]
    end else if (wrAcc && isDir) begin
      dir_reg[idx] <= pwdata[7:0] | INPUT_ONLY[idx] | ~PIN_VALID[idx]; // [R01] [R06] [R14]
    end
  end

  // ----------------------------------------------------------------
  // Pull-up, expansion and alternate selection registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pullLow_reg <= PULL_RESET;
      pullHigh_reg <= PULL_RESET;
      memExp_reg <= MEMEXP_RESET;
      altSel_reg <= ALTSEL_RESET;
    end else if (wrAcc) begin
      if (paddr == PULL_LOW_OFS) begin
        pullLow_reg <= pwdata[7:0];
      end
      if (paddr == PULL_HIGH_OFS) begin
        pullHigh_reg <= pwdata[7:0];
      end
      if (paddr == MEMEXP_OFS) begin
        memExp_reg <= pwdata[7:0];
      end
      if (paddr == ALTSEL_OFS) begin
        altSel_reg <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-port banks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    mpgc_bank_if bif();
    logic [7:0] dirSel;

    // Port 4 follows the expansion register; port 6 high bits carry strobes
    always_comb begin
      dirSel = dir_reg[g];
      if (g == P4_IDX) begin
        dirSel = {8{~memExp_reg[MEMEXP_P4_OUT_BIT]}};                // [R17]
      end else if (g == P6_IDX && expMode) begin
        dirSel = (dir_reg[g] & ~P6_EXP_OUT_MASK) | P6_EXP_IN_MASK;   // [R19]
      end
    end

    assign dirEff[g] = dirSel;
    assign bif.latch = latch_reg[g];
    assign bif.dir = dirSel;
    assign bif.pinIn = pinIn[g];
    assign bif.altOut = (g == P12_IDX) ? rtOutBits :
                        (g == P6_IDX) ? {expAddrStrobe, 1'b0, expWrStrobe, expRdStrobe,
                                         4'h0} : 8'h00;              // [R15] [R19]
    assign bif.altDrive = (g == P12_IDX) ? {8{altSel_reg[ALT_RTP_BIT]}} :
                          (g == P6_IDX) ? (P6_EXP_OUT_MASK & {8{expMode}}) : 8'h00;
    assign bif.analogue = (g == P13_IDX) && altSel_reg[ALT_ANO_BIT]; // [R16]
    // One group bit per port, low register for ports 0-7, high above
    if (PORT_NUM[g] < HIGH_GROUP_BASE) begin : g_low
      assign bif.pullGroup = pullLow_reg[PORT_NUM[g]];               // [R02] [R07] [R10]
    end else begin : g_high
      assign bif.pullGroup = pullHigh_reg[PORT_NUM[g] - HIGH_GROUP_BASE];
    end
    assign readAll[g] = bif.readVal;
    assign outAll[g] = bif.outVal;
    assign oeAll[g] = bif.oeVal;
    // Fixed inputs of port 0 carry no pull-up
    assign pullAll[g] = bif.pullVal & ~INPUT_ONLY[g];                // [R02]

    mpgc_port_bank #(
      .VALID(PIN_VALID[g]),
      .ODRAIN(OPEN_DRAIN[g]),
      .MASK_PULL((g == P6_IDX) ? P6_MASK_PULL : 8'h00)
    ) u_bank (
      .bif(bif)
    );
  end

  // ----------------------------------------------------------------
  // Registered pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pinOut <= '0;
      pinOe <= '0;
      pullupEn <= '0;
      expWaitIn <= 1'b0;
    end else begin
      pinOut <= outAll;                                              // [R18]
      pinOe <= oeAll;
      pullupEn <= pullAll;                                           // [R21]
      expWaitIn <= expMode && pinIn[P6_IDX][P6_WAIT_BIT];            // [R19]
    end
  end

  // ----------------------------------------------------------------
  // External interrupt requests from port 0 pin level
  // ----------------------------------------------------------------
  logic [INT_PINS-1:0] intLvl;

  // Output pins are seen through their latch, so driving them trips the request
  assign intLvl = (~dirEff[P0_IDX][INT_PINS-1:0] & latch_reg[P0_IDX][INT_PINS-1:0]) |
                  (dirEff[P0_IDX][INT_PINS-1:0] & pinIn[P0_IDX][INT_PINS-1:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      intLvl_reg <= '0;
      armed_reg <= 1'b0;
      extIntReq <= '0;
    end else begin
      intLvl_reg <= intLvl;
      armed_reg <= 1'b1;
      extIntReq <= armed_reg ? (intLvl ^ intLvl_reg) : '0;           // [R04]
    end
  end

endmodule
`default_nettype wire

// ### tb/mpgc_board.sv
// Board model driving the port pins
`timescale 1ns/1ps
`default_nettype none
module mpgc_board
  import mpgc_pkg::*;
(
  input wire logic [NPORT-1:0][7:0] pinOut,
  input wire logic [NPORT-1:0][7:0] pinOe,
  input wire logic [NPORT-1:0][7:0] pullupEn,
  input wire logic [NPORT-1:0][7:0] extLvl,
  output logic [NPORT-1:0][7:0] pinIn
);
  // Driven pins read back, released pins see pull-up or board level
  assign pinIn = (pinOe & pinOut) | (~pinOe & (pullupEn | extLvl));
endmodule
`default_nettype wire

// ### tb/mpgc_asserts.sv
// Port checks for the port group block
`timescale 1ns/1ps
`default_nettype none
module mpgc_asserts
  import mpgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [NPORT-1:0][7:0] pinIn,
  input wire logic [NPORT-1:0][7:0] pinOut,
  input wire logic [NPORT-1:0][7:0] pinOe,
  input wire logic [NPORT-1:0][7:0] pullupEn,
  input wire logic [INT_PINS-1:0] extIntReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wrSeen;
  always_ff @(posedge clk) begin
    if (rst) wrSeen <= 1'b0;
    else if (psel && penable && pwrite) wrSeen <= 1'b1;
  end
  a_p0_in_only: assert property ((pinOe[P0_IDX] & 8'hc1) == 8'h00)
    else $error("port 0 fixed input driven");
  a_p0_fix_pull: assert property ((pullupEn[P0_IDX] & 8'hc1) == 8'h00)
    else $error("pull-up on port 0 fixed input");
  a_p7_width: assert property (pinOe[7][7:3] == 5'h00)
    else $error("port 7 missing pin driven");
  a_reset_input: assert property (!wrSeen |-> pinOe == '0 && pullupEn == '0)
    else $error("pin not input after reset");
  a_p6_drain: assert property (pinOut[P6_IDX][3:0] == 4'h0)
    else $error("open drain pin driven high");
  a_p4_group: assert property (pinOe[P4_IDX] inside {8'h00, 8'hff})
    else $error("port 4 direction split");
  a_p1_pull_grp: assert property (pullupEn[1] == 8'h00 || (pullupEn[1] | pinOe[1]) == 8'hff)
    else $error("port 1 pull group split");
  a_pull_input: assert property ((pullupEn & pinOe) == '0)
    else $error("pull-up on output pin");
  a_read_pin: assert property (psel && !penable && !pwrite && paddr == 8'h04 && pinOe[1] == 8'h00
    |=> pinOe[1] == 8'h00 |-> prdata == {24'h0, $past(pinIn[1])})
    else $error("port 1 read not pin level");
  for (genvar i = 1; i < 6; i++) begin : g_int
    a_p0_int_req: assert property (pinOe[0][i] && $past(pinOe[0][i]) && $changed(pinOut[0][i])
      |-> ($past(extIntReq[i]) || extIntReq[i]) or ##1 extIntReq[i])
      else $error("port 0 output change without request");
  end
  c_write: cover property (psel && penable && pwrite);
  c_int: cover property (extIntReq != 6'h00);
  c_err: cover property (penable && pslverr);
endmodule
bind mpgc_top mpgc_asserts u_chk (
  .clk(clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pslverr(pslverr),
  .pinIn(pinIn),
  .pinOut(pinOut),
  .pinOe(pinOe),
  .pullupEn(pullupEn),
  .extIntReq(extIntReq)
);
`default_nettype wire

// ### tb/mcu_port_group_config_tb.sv
// Testbench for the port group block
`timescale 1ns/1ps
`default_nettype none
module mcu_port_group_config_tb
  import mpgc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, re;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic [NPORT-1:0][7:0] pinIn, pinOut, pinOe, pullupEn;
  logic [NPORT-1:0][7:0] extLvl = '0;
  logic [INT_PINS-1:0] extIntReq;
  logic [INT_PINS-1:0] intSeen = '0;
  logic [7:0] rtOutBits = 8'h96;
  logic expRdStrobe = 1'b0, expWrStrobe = 1'b0, expAddrStrobe = 1'b0, expWaitIn;
  int mismatches = 0;
  int tests_run = 0;
  mpgc_top dut (
    .clk(clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pullupEn(pullupEn),
    .extIntReq(extIntReq),
    .rtOutBits(rtOutBits),
    .expRdStrobe(expRdStrobe),
    .expWrStrobe(expWrStrobe),
    .expAddrStrobe(expAddrStrobe),
    .expWaitIn(expWaitIn)
  );
  mpgc_board board (
    .pinOut(pinOut),
    .pinOe(pinOe),
    .pullupEn(pullupEn),
    .extLvl(extLvl),
    .pinIn(pinIn)
  );
  initial forever #5 clk = ~clk;
  always @(posedge clk) intSeen <= intSeen | extIntReq;
  task wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look at pready where it stands, ahead of the edge that samples it
    @(negedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      mismatches++;
      wrap_up();
    end
    rq = prdata;
    re = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rq, e);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task t_reset;
    for (int i = 0; i < 3; i++) rd(8'h40 + 8'(4 * i), 32'hff, "dir");
    rd(8'h04, 32'h0, "p1 pins");
    chk("oe", 32'(pinOe[2:0]), 32'h0);
    $display("t_reset done");
  endtask
  task t_p0;
    wr(8'h40, 32'h0);
    rd(8'h40, 32'hc1, "p0 dir");
    // Requests are only watched here, masking them is up to software
    wr(8'h00, 32'hff);
    tick(3);
    chk("p0 oe", 32'(pinOe[0]), 32'h3e);
    chk("p0 out", 32'(pinOut[0]), 32'h3e);
    chk("p0 int", 32'(intSeen), 32'h3e);
    wr(8'h80, 32'h01);
    tick(2);
    chk("p0 pull out", 32'(pullupEn[0]), 32'h0);
    wr(8'h40, 32'hff);
    tick(2);
    chk("p0 pull in", 32'(pullupEn[0]), 32'h3e);
    $display("t_p0 done");
  endtask
  task t_pull;
    @(posedge clk);
    extLvl[1] <= 8'h3c;
    // No port 1 pin serves as analogue input, so its group may pull
    wr(8'h80, 32'h06);
    tick(2);
    chk("p1 pull", 32'(pullupEn[1]), 32'hff);
    chk("p2 pull", 32'(pullupEn[2]), 32'hff);
    wr(8'h44, 32'h0f);
    wr(8'h04, 32'ha5);
    tick(2);
    chk("p1 pull in", 32'(pullupEn[1]), 32'h0f);
    chk("p1 oe", 32'(pinOe[1]), 32'hf0);
    rd(8'h04, 32'haf, "p1 pulled");
    wr(8'h80, 32'h0);
    // Serial bus mode is never entered, so port 2 bits 5, 6 need no setup
    wr(8'h48, 32'h5a);
    tick(2);
    rd(8'h04, 32'hac, "p1 pins");
    chk("p2 oe", 32'(pinOe[2]), 32'ha5);
    $display("t_pull done");
  endtask
  task t_p4_p6;
    wr(8'h88, 32'h01);
    tick(2);
    chk("p4 oe", 32'(pinOe[4]), 32'hff);
    rd(8'h50, 32'h00, "p4 dir");
    wr(8'h58, 32'h0);
    wr(8'h18, 32'h05);
    tick(2);
    chk("p6 oe", 32'(pinOe[6]), 32'hfa);
    chk("p6 out", 32'(pinOut[6]), 32'h00);
    @(posedge clk);
    extLvl[6] <= 8'h40;
    expRdStrobe <= 1'b1;
    expWrStrobe <= 1'b1;
    expAddrStrobe <= 1'b1;
    wr(8'h88, 32'h03);
    tick(3);
    chk("p6 strobes", 32'(pinOut[6] & 8'hb0), 32'hb0);
    chk("wait in", 32'(expWaitIn), 32'h1);
    $display("t_p4_p6 done");
  endtask
  task t_narrow;
    wr(8'h5c, 32'h0);
    rd(8'h5c, 32'hf8, "p7 dir");
    wr(8'h64, 32'h0);
    rd(8'h64, 32'hfc, "p13 dir");
    wr(8'h8c, 32'h01);
    wr(8'h60, 32'h0);
    tick(2);
    chk("p12 rtp", 32'(pinOut[8]), 32'h96);
    chk("p13 oe", 32'(pinOe[9]), 32'h03);
    wr(8'h8c, 32'h02);
    tick(2);
    chk("p12 latch", 32'(pinOut[8]), 32'h00);
    chk("p13 analogue", 32'(pinOe[9]), 32'h00);
    rd(8'hc0, 32'h0, "unmapped data");
    chk("unmapped err", 32'(re), 32'h1);
    $display("t_narrow done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_p0();
    t_pull();
    t_p4_p6();
    t_narrow();
    wrap_up();
  end
endmodule
`default_nettype wire
